// *** common/xcvr_consts.svh ***
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

`define ADDR_CTRL      8'h00
`define ADDR_START     8'h04
`define ADDR_END       8'h08
`define ADDR_STATUS    8'h0C
`define ADDR_MASK      8'h10
`define ADDR_STATE     8'h14

`define CTRL_CRC_BIT   0
`define CTRL_SLB_BIT   1
`define CTRL_PLB_BIT   2
`define CTRL_W         3
`define CTRL_RST       3'h0

`define START_RST      8'hFB
`define END_RST        8'hFD

`define EV_RX_ERR      0
`define EV_RX_OK       1
`define EV_TX_SENT     2
`define EV_W           3
`define EV_RST         3'h0

`define LAT_CRC        14
`define LAT_PLAIN      8
`define PIPE_OFS       2

`define CRC_POLY       8'h07
`define CRC_INIT       8'hFF

`define LOCK_CYCLES    16
`define AGE_MAX        5'h1F

`endif

// *** common/xcvr_pkg.sv ***
package xcvr_pkg;

   typedef enum logic [1:0] {
      PKT_IDLE = 2'b01,
      PKT_BODY = 2'b10
   } pkt_state_e;

endpackage

// *** rtl/crc_step.sv ***
`timescale 1ns/1ps
// One byte of a bitwise CRC update, MSB first
module crc_step #(
   parameter int          W    = 8,
   parameter logic [W-1:0] POLY = 8'h07
) (
   input  wire logic [W-1:0] crc_i,
   input  wire logic [W-1:0] data_i,
   output logic      [W-1:0] crc_o
);

   initial begin
      if (W < 2) begin
         $error("crc_step: width below 2");
      end
   end

   always_comb begin
      logic [W-1:0] c;
      logic         fb;
      c  = crc_i;
      fb = 1'b0;
      for (int i = W - 1; i >= 0; i--) begin
         fb = c[W-1] ^ data_i[i];
         c  = {c[W-2:0], 1'b0} ^ (fb ? POLY : '0);
      end
      crc_o = c;
   end

endmodule // crc_step

// *** rtl/xcvr_ctrl.sv ***
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module xcvr_ctrl #(
   parameter int LAT_CRC   = `LAT_CRC,
   parameter int LAT_PLAIN = `LAT_PLAIN
) (
   input  wire logic        clock_i,
   input  wire logic        sys_rst_i,
   input  wire logic        tx_reset_i,
   input  wire logic        rx_reset_i,
   input  wire logic        transceiver_power_down_i,
   input  wire logic        transmit_inhibit_i,
   input  wire logic [7:0]  transmit_word_i,
   input  wire logic        transmit_k_i,
   input  wire logic [8:0]  rx_line_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   output logic             irq_o,
   output logic      [8:0]  serial_out_positive_o,
   output logic      [8:0]  serial_out_negative_o,
   output logic      [7:0]  rx_word_o,
   output logic             rx_k_o,
   output logic             rx_valid_o,
   output logic             pll_locked_o
);

   localparam int DEPTH = LAT_CRC - 1;
   localparam int TAP_C = LAT_CRC - `PIPE_OFS;
   localparam int TAP_P = LAT_PLAIN - `PIPE_OFS;

   initial begin
      if (LAT_PLAIN < `PIPE_OFS + 3 || LAT_CRC < LAT_PLAIN) begin
         $error("xcvr_ctrl: latency values not supported");
      end
   end

   wire tx_rst = sys_rst_i | tx_reset_i;
   wire rx_rst = sys_rst_i | rx_reset_i;

   logic [`CTRL_W-1:0] ctrl_reg;
   logic [7:0]         start_reg;
   logic [7:0]         end_reg;
   logic [`EV_W-1:0]   status_reg;
   logic [`EV_W-1:0]   status_next;
   logic [`EV_W-1:0]   mask_reg;

   wire crc_en = ctrl_reg[`CTRL_CRC_BIT];
   wire plb    = ctrl_reg[`CTRL_PLB_BIT];
   wire slb    = ctrl_reg[`CTRL_SLB_BIT];

   // Register decode
   wire wr_ctrl   = reg_wr_i && reg_addr_i == `ADDR_CTRL;
   wire wr_start  = reg_wr_i && reg_addr_i == `ADDR_START;
   wire wr_end    = reg_wr_i && reg_addr_i == `ADDR_END;
   wire wr_status = reg_wr_i && reg_addr_i == `ADDR_STATUS;
   wire wr_mask   = reg_wr_i && reg_addr_i == `ADDR_MASK;

   logic tx_pd_reg;
   logic rx_pd_reg;
   // path blocked during and after power-down
   wire  tx_blocked = transceiver_power_down_i | tx_pd_reg;
   wire  rx_blocked = transceiver_power_down_i | rx_pd_reg;

   // Transmit input stage
   wire [8:0] tx_in   = tx_blocked ? 9'h000 : {transmit_k_i, transmit_word_i};
   wire       tx_sop  = tx_in[8] && tx_in[7:0] == start_reg;
   wire       tx_eop  = tx_in[8] && tx_in[7:0] == end_reg;

   xcvr_pkg::pkt_state_e tx_state_reg;
   xcvr_pkg::pkt_state_e tx_state_next;
   logic [7:0] tx_crc_reg;
   logic [7:0] tx_crc_d1_reg;
   logic [7:0] tx_crc_d2_reg;
   logic [7:0] tx_crc_upd;
   logic       tx_par_reg;
   logic       tx_par_d1_reg;
   logic       tx_par_d2_reg;

   wire tx_in_body = tx_state_reg == xcvr_pkg::PKT_BODY;
   wire tx_restart = tx_state_reg == xcvr_pkg::PKT_IDLE && tx_sop;
   wire tx_beat    = tx_in_body && !tx_in[8];
   wire tx_close   = tx_in_body && tx_eop;
   wire tx_insert  = crc_en && tx_close;

   // pad byte brings the packet's ones count to even
   wire [7:0] crc_byte = tx_crc_d2_reg;
   wire [7:0] pad_byte = {7'h00, tx_par_d2_reg ^ (^crc_byte)};

   always_comb begin
      tx_state_next = tx_state_reg;
      case (tx_state_reg)
         xcvr_pkg::PKT_IDLE: begin
            if (tx_sop) begin
               tx_state_next = xcvr_pkg::PKT_BODY;
            end
         end
         xcvr_pkg::PKT_BODY: begin
            if (tx_eop) begin
               tx_state_next = xcvr_pkg::PKT_IDLE;
            end
         end
         default: tx_state_next = xcvr_pkg::PKT_IDLE;
      endcase
   end

   crc_step #(
      .W    (8),
      .POLY (`CRC_POLY)
   ) u_tx_crc (
      .crc_i  (tx_crc_reg),
      .data_i (tx_in[7:0]),
      .crc_o  (tx_crc_upd)
   );

   // transmit state cleared by its own reset
   always_ff @(posedge clock_i) begin
      if (tx_rst) begin
         tx_state_reg <= xcvr_pkg::PKT_IDLE;
      end else begin
         tx_state_reg <= tx_state_next;
      end
   end

   // History keeps the CRC and parity from before the two trailing slots
   always_ff @(posedge clock_i) begin
      if (tx_rst || tx_restart) begin
         tx_crc_reg    <= `CRC_INIT;
         tx_crc_d1_reg <= `CRC_INIT;
         tx_crc_d2_reg <= `CRC_INIT;
         tx_par_reg    <= 1'b0;
         tx_par_d1_reg <= 1'b0;
         tx_par_d2_reg <= 1'b0;
      end else if (tx_beat) begin
         tx_crc_reg    <= tx_crc_upd;
         tx_crc_d1_reg <= tx_crc_reg;
         tx_crc_d2_reg <= tx_crc_d1_reg;
         tx_par_reg    <= tx_par_reg ^ (^tx_in[7:0]);
         tx_par_d1_reg <= tx_par_reg;
         tx_par_d2_reg <= tx_par_d1_reg;
      end
   end

   // Transmit delay line; stages 1 and 2 take the fixed trailer
   logic [8:0] pipe_q    [DEPTH];
   logic [8:0] pipe_next [DEPTH];

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_pipe
         if (gi == 0) begin : g_in
            assign pipe_next[gi] = tx_in;
         end else if (gi == 1) begin : g_pad
            assign pipe_next[gi] = tx_insert ? {1'b0, pad_byte} : pipe_q[0];
         end else if (gi == 2) begin : g_crc
            assign pipe_next[gi] = tx_insert ? {1'b0, crc_byte} : pipe_q[1];
         end else begin : g_sh
            assign pipe_next[gi] = pipe_q[gi-1];
         end
         always_ff @(posedge clock_i) begin
            if (tx_rst) begin
               pipe_q[gi] <= 9'h000;
            end else begin
               pipe_q[gi] <= pipe_next[gi];
            end
         end
      end
   endgenerate

   // tap picks the latency; switching mode mid-stream repeats or skips words
   wire [8:0] tx_tap = crc_en ? pipe_q[TAP_C] : pipe_q[TAP_P];

   logic [8:0] pos_reg;
   logic [8:0] neg_reg;

   always_ff @(posedge clock_i) begin
      if (tx_rst) begin
         pos_reg <= 9'h000;
         neg_reg <= 9'h1FF;
      end else if (transmit_inhibit_i) begin
         pos_reg <= 9'h000;
         neg_reg <= 9'h000;
      end else begin
         pos_reg <= tx_tap;
         neg_reg <= ~tx_tap;
      end
   end

   // Receive line synchroniser
   logic [8:0] rx_meta_reg;
   logic [8:0] rx_sync_reg;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rx_meta_reg <= 9'h000;
         rx_sync_reg <= 9'h000;
      end else begin
         rx_meta_reg <= rx_line_i;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // parallel loopback overrides the serial path
   wire [8:0] rx_src = plb ? tx_tap : (slb ? pos_reg : rx_sync_reg);

   logic [8:0] rx_word_reg;
   xcvr_pkg::pkt_state_e rx_state_reg;
   xcvr_pkg::pkt_state_e rx_state_next;
   logic [7:0] rx_crc_reg;
   logic [7:0] rx_crc_d1_reg;
   logic [7:0] rx_crc_d2_reg;
   logic [7:0] rx_crc_upd;
   logic [7:0] rx_b1_reg;
   logic [7:0] rx_b2_reg;
   logic       rx_ok_reg;
   logic       rx_err_reg;
   logic       tx_sent_reg;

   wire rx_sop     = rx_word_reg[8] && rx_word_reg[7:0] == start_reg;
   wire rx_eop     = rx_word_reg[8] && rx_word_reg[7:0] == end_reg;
   wire rx_in_body = rx_state_reg == xcvr_pkg::PKT_BODY;
   wire rx_restart = rx_state_reg == xcvr_pkg::PKT_IDLE && rx_sop;
   wire rx_beat    = rx_in_body && !rx_word_reg[8];
   wire rx_close   = crc_en && rx_in_body && rx_eop;
   // CRC before the trailer against the carried CRC byte
   wire rx_match   = rx_crc_d2_reg == rx_b2_reg;

   always_comb begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         xcvr_pkg::PKT_IDLE: begin
            if (rx_sop) begin
               rx_state_next = xcvr_pkg::PKT_BODY;
            end
         end
         xcvr_pkg::PKT_BODY: begin
            if (rx_eop) begin
               rx_state_next = xcvr_pkg::PKT_IDLE;
            end
         end
         default: rx_state_next = xcvr_pkg::PKT_IDLE;
      endcase
   end

   crc_step #(
      .W    (8),
      .POLY (`CRC_POLY)
   ) u_rx_crc (
      .crc_i  (rx_crc_reg),
      .data_i (rx_word_reg[7:0]),
      .crc_o  (rx_crc_upd)
   );

   // receive state cleared by its own reset
   always_ff @(posedge clock_i) begin
      if (rx_rst) begin
         rx_word_reg  <= 9'h000;
         rx_state_reg <= xcvr_pkg::PKT_IDLE;
         rx_ok_reg    <= 1'b0;
         rx_err_reg   <= 1'b0;
      end else begin
         rx_word_reg  <= rx_src;
         rx_state_reg <= rx_state_next;
         rx_ok_reg    <= rx_close && rx_match;
         rx_err_reg   <= rx_close && !rx_match;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rx_rst || rx_restart) begin
         rx_crc_reg    <= `CRC_INIT;
         rx_crc_d1_reg <= `CRC_INIT;
         rx_crc_d2_reg <= `CRC_INIT;
         rx_b1_reg     <= 8'h00;
         rx_b2_reg     <= 8'h00;
      end else if (rx_beat) begin
         rx_crc_reg    <= rx_crc_upd;
         rx_crc_d1_reg <= rx_crc_reg;
         rx_crc_d2_reg <= rx_crc_d1_reg;
         rx_b1_reg     <= rx_word_reg[7:0];
         rx_b2_reg     <= rx_b1_reg;
      end
   end

   // hold invalid until the path reset after power-down
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tx_pd_reg <= 1'b0;
         rx_pd_reg <= 1'b0;
      end else begin
         tx_pd_reg <= transceiver_power_down_i | (tx_pd_reg & ~tx_reset_i);
         rx_pd_reg <= transceiver_power_down_i | (rx_pd_reg & ~rx_reset_i);
      end
   end

   always_ff @(posedge clock_i) begin
      if (rx_rst) begin
         rx_word_o  <= 8'h00;
         rx_k_o     <= 1'b0;
         rx_valid_o <= 1'b0;
      end else begin
         rx_word_o  <= rx_word_reg[7:0];
         rx_k_o     <= rx_word_reg[8];
         rx_valid_o <= !rx_blocked;
      end
   end

   // lock counter sees only the system reset
   logic [4:0] lock_cnt_reg;
   logic       lock_reg;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         lock_cnt_reg <= 5'h00;
         lock_reg     <= 1'b0;
      end else if (!lock_reg) begin
         lock_cnt_reg <= lock_cnt_reg + 5'h01;
         lock_reg     <= lock_cnt_reg == 5'(`LOCK_CYCLES - 1);
      end
   end

   // Registers; an event in the clearing cycle stays set
   wire [`EV_W-1:0] events = {tx_sent_reg, rx_ok_reg, rx_err_reg};
   wire [`EV_W-1:0] w1c    = wr_status ? reg_wdata_i[`EV_W-1:0] : '0;
   assign status_next = (status_reg & ~w1c) | events;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl_reg    <= `CTRL_RST;
         start_reg   <= `START_RST;
         end_reg     <= `END_RST;
         status_reg  <= `EV_RST;
         mask_reg    <= `EV_RST;
         tx_sent_reg <= 1'b0;
         irq_o       <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_reg <= reg_wdata_i[`CTRL_W-1:0];
         if (wr_start) start_reg <= reg_wdata_i[7:0];
         if (wr_end) end_reg <= reg_wdata_i[7:0];
         if (wr_mask) mask_reg <= reg_wdata_i[`EV_W-1:0];
         status_reg  <= status_next;
         tx_sent_reg <= tx_close && !tx_rst;
         irq_o       <= |(status_reg & mask_reg);
      end
   end

   wire [31:0] state_word = {28'h000_0000, transceiver_power_down_i,
                             rx_in_body, tx_in_body, lock_reg};
   wire [31:0] rd_mux =
      reg_addr_i == `ADDR_CTRL   ? {29'h0000_0000, ctrl_reg} :
      reg_addr_i == `ADDR_START  ? {24'h00_0000, start_reg} :
      reg_addr_i == `ADDR_END    ? {24'h00_0000, end_reg} :
      reg_addr_i == `ADDR_STATUS ? {29'h0000_0000, status_reg} :
      reg_addr_i == `ADDR_MASK   ? {29'h0000_0000, mask_reg} :
      reg_addr_i == `ADDR_STATE  ? state_word : 32'h0000_0000;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   assign serial_out_positive_o = pos_reg;
   assign serial_out_negative_o = neg_reg;
   assign pll_locked_o          = lock_reg;

   // Checks; age counts settled cycles since reset or a mode change
   logic [4:0] age_reg;
   logic       crc_en_d_reg;

   always_ff @(posedge clock_i) begin
      crc_en_d_reg <= crc_en;
      if (tx_rst || crc_en != crc_en_d_reg) begin
         age_reg <= 5'h00;
      end else if (age_reg != `AGE_MAX) begin
         age_reg <= age_reg + 5'h01;
      end
   end

   default clocking cb @(posedge clock_i); endclocking

   AST_INHIBIT_ZERO: assert property (disable iff (tx_rst)
      transmit_inhibit_i |=> pos_reg == 9'h000)
      else $error("positive output not zero under inhibit");
   AST_LAT_PLAIN: assert property (disable iff (tx_rst)
      age_reg == `AGE_MAX && !crc_en && !$past(transmit_inhibit_i)
      |-> pos_reg == $past(tx_in, 8))
      else $error("plain transmit latency wrong");
   AST_CRC_INSERT: assert property (disable iff (tx_rst)
      tx_insert |=> pipe_q[2][7:0] == $past(tx_crc_d2_reg)
      && (^{pipe_q[2][7:0], pipe_q[1][7:0]}) == $past(tx_par_d2_reg))
      else $error("crc or pad byte wrong");
   AST_PLB_PATH: assert property (disable iff (tx_rst || rx_rst)
      plb && !transmit_inhibit_i |=> rx_word_reg == $past(tx_tap) && pos_reg == $past(tx_tap))
      else $error("parallel loopback path wrong");
   AST_SLB_PADS: assert property (disable iff (rx_rst)
      slb && !plb |=> rx_word_reg == $past(pos_reg))
      else $error("serial loopback not from pads");
   AST_RX_CHECK: assert property (disable iff (rx_rst)
      rx_close |=> rx_ok_reg == $past(rx_match) && rx_err_reg == !$past(rx_match))
      else $error("receive crc verdict wrong");
   AST_TX_RESET: assert property (disable iff (sys_rst_i)
      tx_reset_i |=> pipe_q[0] == 9'h000 && tx_crc_reg == `CRC_INIT && !tx_in_body)
      else $error("transmit reset incomplete");
   AST_RX_RESET: assert property (disable iff (sys_rst_i)
      rx_reset_i |=> rx_word_reg == 9'h000 && !rx_in_body && !rx_valid_o)
      else $error("receive reset incomplete");
   AST_LOCK_HOLD: assert property (disable iff (sys_rst_i)
      lock_reg |=> lock_reg)
      else $error("lock lost without system reset");
   AST_PD_BLOCK: assert property (disable iff (sys_rst_i)
      transceiver_power_down_i ##1 !rx_reset_i |=> !rx_valid_o)
      else $error("receive valid during power-down");

   CVR_INSERT: cover property (disable iff (tx_rst) tx_insert);
   CVR_RX_OK: cover property (disable iff (rx_rst) rx_ok_reg);
   CVR_SLB_PKT: cover property (disable iff (rx_rst) slb && !plb && rx_close);
   CVR_PD_RECOVER: cover property (disable iff (sys_rst_i) rx_pd_reg ##1 rx_reset_i ##2 rx_valid_o);

endmodule // xcvr_ctrl

// *** tb/line_source.sv ***
`timescale 1ns/1ps
`include "xcvr_consts.svh"
// Remote line end: frames packets, toggles an idle pattern between them
module line_source (
   input  wire logic       clock_i,
   output logic      [8:0] rx_line_o
);
   logic [8:0] word_q[$];

   function automatic logic [7:0] crc8(input logic [7:0] d[6]);
      logic [7:0] c;
      c = `CRC_INIT;
      foreach (d[i]) begin
         c = c ^ d[i];
         for (int b = 0; b < 8; b++) begin
            c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
         end
      end
      return c;
   endfunction

   function automatic logic par(input logic [7:0] d[6], input logic [7:0] c);
      logic p;
      p = ^c;
      foreach (d[i]) p = p ^ (^d[i]);
      return p;
   endfunction

   task automatic send(input logic [7:0] sc, input logic [7:0] ec, input logic bad, input logic cut,
                       input logic [7:0] d[6]);
      logic [7:0] c;
      c = crc8(d) ^ {7'h00, bad};
      word_q.push_back({1'b1, sc});
      foreach (d[i]) word_q.push_back({1'b0, d[i]});
      if (!cut) begin
         word_q.push_back({1'b0, c});
         word_q.push_back({8'h00, par(d, c)});
         word_q.push_back({1'b1, ec});
      end
   endtask

   // Idle bytes change every cycle so a stale value never looks valid
   initial rx_line_o = 9'h0A5;
   always @(posedge clock_i) begin
      if (word_q.size() != 0) rx_line_o <= word_q.pop_front();
      else rx_line_o <= {1'b0, ~rx_line_o[7:0]};
   end
endmodule // line_source

// *** tb/xcvr_ctrl_test.sv ***
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module xcvr_ctrl_test;
   typedef struct {int due; logic [31:0] v; logic [8:0] n;} note_s;
   localparam int LP = `LAT_PLAIN;
   localparam int LC = `LAT_CRC;
   logic        clock_i, sys_rst_i, tx_reset_i, rx_reset_i, transceiver_power_down_i;
   logic        transmit_inhibit_i, transmit_k_i, reg_wr_i, reg_rd_i, irq_o, rx_k_o, rx_valid_o, pll_locked_o;
   logic [7:0]  transmit_word_i, reg_addr_i, rx_word_o;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   logic [8:0]  rx_line_i, serial_out_positive_o, serial_out_negative_o;
   int          cyc, n_errors, comparisons, lbk;
   note_s       q_tx[$], q_rd[$], q_rx[$];
   logic [7:0]  d[6];
   logic [7:0]  ra[7] = '{`ADDR_CTRL, `ADDR_START, `ADDR_END, `ADDR_STATUS, `ADDR_MASK, `ADDR_STATE, 8'h20};
   logic [31:0] rv[7] = '{32'h0, 32'hFB, 32'hFD, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] lv[3] = '{32'h2, 32'h1, 32'h0};

   xcvr_ctrl i_xcvr_ctrl (.clock_i, .sys_rst_i, .tx_reset_i, .rx_reset_i, .transceiver_power_down_i,
      .transmit_inhibit_i, .transmit_word_i, .transmit_k_i, .rx_line_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .serial_out_positive_o, .serial_out_negative_o,
      .rx_word_o, .rx_k_o, .rx_valid_o, .pll_locked_o);
   line_source i_line_source (.clock_i(clock_i), .rx_line_o(rx_line_i));

   always #12.5 clock_i = ~clock_i;

   task wrap_up;
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Run length is about 520 cycles, so this only trips on a hang
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up;
      end
   end

   task check(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t: saw %h, expected %h", $time, s, e);
      end
   endtask

   always @(negedge clock_i) begin
      if (q_tx.size() != 0 && q_tx[0].due == cyc) begin
         check(serial_out_positive_o, q_tx[0].v);
         check(serial_out_negative_o, q_tx[0].n);
         void'(q_tx.pop_front());
      end
      if (q_rd.size() != 0 && q_rd[0].due == cyc) begin
         check(reg_rdata_o, q_rd[0].v);
         void'(q_rd.pop_front());
      end
      if (q_rx.size() != 0 && q_rx[0].due == cyc) begin
         check({rx_k_o, rx_word_o}, q_rx[0].v);
         void'(q_rx.pop_front());
      end
   end

   task wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      q_rd.push_back('{cyc + 2, e, 9'h000});
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(posedge clock_i);
   endtask

   // Mode 0 passes the word, 1 expects inhibit zeros, 2 leaves it unchecked
   task tx(input logic [8:0] w, input logic [8:0] e, input int m, input int lat);
      transmit_k_i <= w[8];
      transmit_word_i <= w[7:0];
      if (m != 2) q_tx.push_back('{cyc + 1 + lat, 32'(m == 1 ? 9'h000 : e), m == 1 ? 9'h000 : ~e});
      // Loopback word reaches rx_word_o lbk cycles after the pads
      if (m != 2 && lbk != 0) q_rx.push_back('{cyc + 1 + lat + lbk, 32'(m == 1 ? 9'h000 : e), 9'h000});
      @(posedge clock_i);
   endtask

   // Plain stream; inhibit for ten words from ih, transmit reset at rs, pz for power-down zeros
   task stream(input int n, input int ih, input int rs, input bit pz);
      logic [8:0] w;
      logic [8:0] e;
      int         m;
      for (int i = 0; i < n; i++) begin
         w = {1'b0, 8'($urandom)};
         e = ((pz && i <= rs) || (i > rs - LP && i <= rs)) ? 9'h000 : w;
         m = (i == ih - LP || i == ih + 10 - LP || i == rs - LP) ? 2 : (i > ih - LP && i < ih + 10 - LP);
         transmit_inhibit_i <= (i >= ih && i < ih + 10);
         tx_reset_i <= (i == rs);
         tx(w, e, m, LP);
      end
      repeat (LP + 2) tx(9'h000, 9'h000, 0, LP);
   endtask

   task pkt(input int m);
      logic [7:0] c;
      logic       p;
      foreach (d[i]) d[i] = 8'($urandom);
      c = i_line_source.crc8(d);
      p = i_line_source.par(d, c);
      tx({1'b1, `START_RST}, {1'b1, `START_RST}, m, LC);
      foreach (d[i]) tx({1'b0, d[i]}, {1'b0, d[i]}, m, LC);
      tx(9'h0AA, {1'b0, c}, m, LC);
      tx(9'h0A5, {8'h00, p}, m, LC);
      tx({1'b1, `END_RST}, {1'b1, `END_RST}, m, LC);
      repeat (LC + 2) tx(9'h000, 9'h000, m, LC);
      repeat (20) @(posedge clock_i);
   endtask

   initial begin
      {clock_i, tx_reset_i, rx_reset_i, transceiver_power_down_i, transmit_inhibit_i} = 5'h0;
      {transmit_k_i, reg_wr_i, reg_rd_i, transmit_word_i, reg_addr_i, reg_wdata_i} = 51'h0;
      {cyc, n_errors, comparisons, lbk} = 128'h0;
      sys_rst_i = 1'b1;
      void'($urandom(32'h691c));
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      foreach (ra[i]) rd(ra[i], rv[i]);
      repeat (10) @(posedge clock_i);
      rd(`ADDR_STATE, 32'h1);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      stream(30, 10, -100, 0);
      stream(24, -100, 10, 0);
      wr(`ADDR_MASK, 32'h7);
      wr(`ADDR_CTRL, 32'h3);
      repeat (20) @(posedge clock_i);
      lbk = 2;
      pkt(0);
      rd(`ADDR_STATUS, 32'h6);
      check(irq_o, 1'b1);
      wr(`ADDR_STATUS, 32'h7);
      rd(`ADDR_STATUS, 32'h0);
      check(irq_o, 1'b0);
      wr(`ADDR_CTRL, 32'h7);
      wr(`ADDR_MASK, 32'h0);
      repeat (20) @(posedge clock_i);
      lbk = 1;
      pkt(0);
      lbk = 0;
      rd(`ADDR_STATUS, 32'h6);
      check(irq_o, 1'b0);
      wr(`ADDR_STATUS, 32'h7);
      wr(`ADDR_CTRL, 32'h3);
      repeat (20) @(posedge clock_i);
      transmit_inhibit_i <= 1'b1;
      pkt(2);
      transmit_inhibit_i <= 1'b0;
      rd(`ADDR_STATUS, 32'h4);
      wr(`ADDR_STATUS, 32'h7);
      wr(`ADDR_CTRL, 32'h1);
      wr(`ADDR_START, 32'h3C);
      wr(`ADDR_END, 32'h7C);
      for (int b = 0; b < 3; b++) begin
         foreach (d[i]) d[i] = 8'($urandom);
         i_line_source.send(b == 2 ? `START_RST : 8'h3C, b == 2 ? `END_RST : 8'h7C, b == 1, 1'b0, d);
         repeat (30) @(posedge clock_i);
         rd(`ADDR_STATUS, lv[b]);
         wr(`ADDR_STATUS, 32'h7);
      end
      i_line_source.send(8'h3C, 8'h7C, 1'b0, 1'b1, d);
      repeat (20) @(posedge clock_i);
      rd(`ADDR_STATE, 32'h5);
      rx_reset_i <= 1'b1;
      @(posedge clock_i);
      rx_reset_i <= 1'b0;
      @(posedge clock_i);
      rd(`ADDR_STATE, 32'h1);
      wr(`ADDR_CTRL, 32'h0);
      transceiver_power_down_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      rd(`ADDR_STATE, 32'h9);
      check(rx_valid_o, 1'b0);
      transceiver_power_down_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      check(rx_valid_o, 1'b0);
      stream(20, -100, 10, 1);
      rx_reset_i <= 1'b1;
      @(posedge clock_i);
      rx_reset_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      check(rx_valid_o, 1'b1);
      check(pll_locked_o, 1'b1);
      repeat (5) @(posedge clock_i);
      wrap_up;
   end
endmodule // xcvr_ctrl_test
